// >>> core/scl_pkg.sv
// strap configuration loader: shared constants, register map, state codes and decode functions
// assumes a 10 MHz core clock and an APB master with 32-bit data
package scl_pkg;

  localparam int CLK_PERIOD_NS       = 100;
  // settle time after reset release before probing the straps
  localparam int STRAP_SETTLE_NS     = 2000;
  localparam int STRAP_SETTLE_CYC    = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // time each probe phase is driven before the pins are sampled
  localparam int PHASE_SETTLE_NS     = 500;
  localparam int PHASE_SETTLE_CYC    = (PHASE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STRAP_SETTLE_CNT = 8'(STRAP_SETTLE_CYC - 1);
  localparam logic [7:0] PHASE_SETTLE_CNT = 8'(PHASE_SETTLE_CYC - 1);

  localparam int STRAP_PINS  = 4;
  localparam int PROBE_LINES = 15;
  localparam int NUM_PHASES  = 4;

  // strap codes by connection
  localparam logic [3:0] CODE_VSS        = 4'h0;
  localparam logic [3:0] CODE_PORT0_LED2 = 4'h1;

  // bit positions inside each 4-bit strap code
  localparam int P0_ORDER_BIT     = 3;
  localparam int P0_ADDR_MSB      = 2;
  localparam int P1_MASTER_BIT    = 3;
  localparam int P1_PAUSE_BIT     = 2;
  localparam int P1_ADV_MSB       = 1;
  localparam int P2_AUTONEG_BIT   = 3;
  localparam int P2_XOVER_BIT     = 2;
  localparam int P2_EDET_DIS_BIT  = 1;
  localparam int P2_POWERDOWN_BIT = 0;
  localparam int P3_MODE_MSB      = 2;

  // media modes
  localparam logic [2:0] MODE_QSERIAL_COPPER = 3'h0;
  localparam logic [2:0] MODE_SERIAL_COPPER  = 3'h1;
  localparam logic [2:0] MODE_QSERIAL_FIBER  = 3'h2;

  // register byte offsets
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_ADDR   = 12'h004;
  localparam logic [11:0] OFS_ADVERT = 12'h008;
  localparam logic [11:0] OFS_CTRL   = 12'h00c;

  // advertisement register fields
  localparam int ADV_TECH_LSB   = 0;
  localparam int ADV_GIG_HALF   = 4;
  localparam int ADV_FIBER_LSB  = 5;
  localparam int ADV_PAUSE_LSB  = 7;
  localparam int ADV_FPAUSE_LSB = 9;
  localparam int ADV_MASTER_LSB = 11;
  // control register fields
  localparam int CTL_EDET_LSB   = 0;
  localparam int CTL_XOVER      = 2;
  localparam int CTL_MODE_LSB   = 3;
  localparam int CTL_SANEG      = 6;
  localparam int CTL_QANEG      = 7;
  localparam int CTL_PD_COPPER  = 8;
  localparam int CTL_PD_FIBER   = 9;
  localparam int CTL_PD_QSER    = 10;

  // reset values of the field registers before the straps load
  localparam logic [12:0] ADVERT_RESET = 13'h0000;
  localparam logic [10:0] CTRL_RESET   = 11'h000;

  typedef enum logic [4:0] {
    ST_WAIT   = 5'b00001,
    ST_DRIVE  = 5'b00010,
    ST_SAMPLE = 5'b00100,
    ST_LOAD   = 5'b01000,
    ST_DONE   = 5'b10000
  } scl_state_type;

  // {4_0.8:5, 9_0.8, 4_1.6:5}
  function automatic logic [6:0] scl_advert(input logic [1:0] sel);
    logic [6:0] r;
    r = {(sel[1] ? 4'hf : 4'h0), sel[0], (sel[0] ? 2'h3 : 2'h1)};
    return r;
  endfunction

  // {0_4.11, 0_1.11, 0_0.11}
  function automatic logic [2:0] scl_powerdown(input logic powerdown, input logic [2:0] mode);
    logic [2:0] r;
    r = 3'h0;
    if (powerdown) begin
      unique case (mode)
        3'h0, 3'h1:       r = 3'b001;
        3'h2, 3'h3, 3'h4: r = 3'b010;
        3'h5:             r = 3'b100;
        default:          r = 3'b011;
      endcase
    end
    return r;
  endfunction

  function automatic logic [1:0] scl_lower_addr(input logic order, input logic [1:0] port);
    logic [1:0] r;
    r = order ? ~port : port;
    return r;
  endfunction

  // merge write data into a register word by byte strobes
  function automatic logic [31:0] scl_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// >>> core/scl_sync.sv
// strap configuration loader: two-stage synchroniser for pin levels
// assumes inputs are asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module scl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk, // core clock
  input  wire logic             reset,    // async reset, active high
  input  wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic      [WIDTH-1:0] sync_out  // synchronised levels
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// >>> core/scl_strap_map.sv
// strap configuration loader: maps four strap codes onto default register fields
// assumes codes are stable while the result is loaded
`timescale 1ns/1ps
`default_nettype none
module scl_strap_map (
  input  wire logic [3:0]  code0,       // strap pin 0 code
  input  wire logic [3:0]  code1,       // strap pin 1 code
  input  wire logic [3:0]  code2,       // strap pin 2 code
  input  wire logic [3:0]  code3,       // strap pin 3 code
  output logic      [2:0]  upper_port_address, // address bits 4:2
  output logic             port_number_order,  // port numbering order
  output logic      [12:0] advert_dflt, // advertisement defaults
  output logic      [10:0] ctrl_dflt    // control defaults
);

  logic [1:0] copper_advert_select;
  logic [2:0] mode;
  logic [6:0] advert_bits;

  always_comb begin
    port_number_order    = code0[scl_pkg::P0_ORDER_BIT];
    upper_port_address   = code0[scl_pkg::P0_ADDR_MSB -: 3];
    copper_advert_select = code1[scl_pkg::P1_ADV_MSB -: 2];
    mode                 = code3[scl_pkg::P3_MODE_MSB -: 3];
    advert_bits          = scl_pkg::scl_advert(copper_advert_select);
    advert_dflt = '0;
    advert_dflt[scl_pkg::ADV_FIBER_LSB +: 2] = advert_bits[1:0];
    advert_dflt[scl_pkg::ADV_GIG_HALF]       = advert_bits[2];
    advert_dflt[scl_pkg::ADV_TECH_LSB +: 4]  = advert_bits[6:3];
    advert_dflt[scl_pkg::ADV_PAUSE_LSB +: 2]  = {2{code1[scl_pkg::P1_PAUSE_BIT]}};
    advert_dflt[scl_pkg::ADV_FPAUSE_LSB +: 2] = {2{code1[scl_pkg::P1_PAUSE_BIT]}};
    advert_dflt[scl_pkg::ADV_MASTER_LSB +: 2] = {2{code1[scl_pkg::P1_MASTER_BIT]}};
    ctrl_dflt = '0;
    ctrl_dflt[scl_pkg::CTL_EDET_LSB +: 2] = {2{~code2[scl_pkg::P2_EDET_DIS_BIT]}};
    ctrl_dflt[scl_pkg::CTL_XOVER]         = code2[scl_pkg::P2_XOVER_BIT];
    ctrl_dflt[scl_pkg::CTL_MODE_LSB +: 3] = mode;
    ctrl_dflt[scl_pkg::CTL_SANEG]         = code2[scl_pkg::P2_AUTONEG_BIT];
    ctrl_dflt[scl_pkg::CTL_QANEG]         = code2[scl_pkg::P2_AUTONEG_BIT];
    {ctrl_dflt[scl_pkg::CTL_PD_QSER], ctrl_dflt[scl_pkg::CTL_PD_FIBER], ctrl_dflt[scl_pkg::CTL_PD_COPPER]} =
      scl_pkg::scl_powerdown(code2[scl_pkg::P2_POWERDOWN_BIT], mode);
  end

endmodule
`default_nettype wire

// >>> core/scl_loader.sv
// strap configuration loader top: probes the strap pins after reset, decodes them,
// presets the default fields and serves them over an APB slave
// assumes strap pins and clock selects are board levels asynchronous to core_clk
// assumes each strap pin is tied to ground or to one probe line on the board
// assumes software waits on pready; requests made before the load are stalled
// assumes one APB master; pstrb selects the byte lanes of a write
`timescale 1ns/1ps
`default_nettype none
module scl_loader (
  input  wire logic        core_clk,            // core clock, 10 MHz
  input  wire logic        reset,               // async reset, active high
  input  wire logic [3:0]  strap_pin,           // configuration strap pins
  input  wire logic [1:0]  clk_sel_pin,         // reference clock select straps
  output logic      [14:0] probe_led,           // led lines driven with probe pattern
  output logic             probe_active,        // probe pattern on led lines
  output logic             cfg_loaded,          // defaults loaded
  output logic      [1:0]  ref_clk_select,      // chosen reference clock option
  output logic      [4:0]  port0_address,       // port 0 address
  output logic      [4:0]  port1_address,       // port 1 address
  output logic      [4:0]  port2_address,       // port 2 address
  output logic      [4:0]  port3_address,       // port 3 address
  output logic      [12:0] advert_cfg,          // advertisement field register
  output logic      [10:0] ctrl_cfg,            // control field register
  input  wire logic [11:0] paddr,               // apb address
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb enable
  input  wire logic        pwrite,              // apb direction
  input  wire logic [31:0] pwdata,              // apb write data
  input  wire logic [3:0]  pstrb,               // apb byte strobes
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr              // apb error
);

  scl_pkg::scl_state_type state_reg;
  scl_pkg::scl_state_type state_next;

  logic [7:0]  count_reg;
  logic [1:0]  phase_reg;
  logic [3:0]  code_reg [scl_pkg::STRAP_PINS];
  logic [1:0]  clk_sel_reg;
  logic [3:0]  strap_sync;
  logic [1:0]  clk_sel_sync;
  logic [2:0]  upper_port_address;
  logic        port_number_order;
  logic [2:0]  upper_addr_reg;
  logic        order_reg;
  logic [12:0] advert_dflt;
  logic [10:0] ctrl_dflt;
  logic [12:0] advert_reg;
  logic [10:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic        access;
  logic        wr_strobe;
  logic        mapped;
  logic        writable;
  logic [31:0] read_mux;
  logic [31:0] advert_word;
  logic [31:0] ctrl_word;
  logic [15:0] codes_word;
  logic [1:0]  probe_phase;
  logic        loaded;
  logic        ready_reg;
  logic        complete;
  logic        sel_status;
  logic        sel_addr;
  logic        sel_advert;
  logic        sel_ctrl;
  logic        adv_we;
  logic        ctrl_we;
  logic [4:0]  port_addr_reg [4];

  scl_sync #(
    .WIDTH (4)
  ) u_strap_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (strap_pin),
    .sync_out (strap_sync)
  );

  scl_sync #(
    .WIDTH (2)
  ) u_clk_sel_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (clk_sel_pin),
    .sync_out (clk_sel_sync)
  );

  scl_strap_map u_map (
    .code0              (code_reg[0]),
    .code1              (code_reg[1]),
    .code2              (code_reg[2]),
    .code3              (code_reg[3]),
    .upper_port_address (upper_port_address),
    .port_number_order  (port_number_order),
    .advert_dflt        (advert_dflt),
    .ctrl_dflt          (ctrl_dflt)
  );

  // sequencer: wait after release, then four drive/sample phases, then load
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      scl_pkg::ST_WAIT: begin
        if (count_reg == 8'h00) begin
          state_next = scl_pkg::ST_DRIVE;
        end
      end
      scl_pkg::ST_DRIVE: begin
        if (count_reg == 8'h00) begin
          state_next = scl_pkg::ST_SAMPLE;
        end
      end
      scl_pkg::ST_SAMPLE: begin
        if (phase_reg == 2'(scl_pkg::NUM_PHASES - 1)) begin
          state_next = scl_pkg::ST_LOAD;
        end else begin
          state_next = scl_pkg::ST_DRIVE;
        end
      end
      scl_pkg::ST_LOAD: begin
        state_next = scl_pkg::ST_DONE;
      end
      scl_pkg::ST_DONE: begin
        state_next = scl_pkg::ST_DONE;
      end
      default: begin
        // a corrupted state code restarts the probe from the settle wait
        state_next = scl_pkg::ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= scl_pkg::ST_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_reg <= scl_pkg::STRAP_SETTLE_CNT;
    end else if (state_reg == scl_pkg::ST_SAMPLE) begin
      count_reg <= scl_pkg::PHASE_SETTLE_CNT;
    end else if (state_reg == scl_pkg::ST_WAIT && count_reg == 8'h00) begin
      count_reg <= scl_pkg::PHASE_SETTLE_CNT;
    end else if (count_reg != 8'h00) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase_reg <= 2'h0;
    end else if (state_reg == scl_pkg::ST_SAMPLE) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // the lines show the coming phase from the same edge that starts it, so the pattern
  // has crossed the synchroniser long before the sample edge
  always_comb begin
    probe_phase = phase_reg;
    if (state_reg == scl_pkg::ST_SAMPLE) begin
      probe_phase = phase_reg + 2'h1;
    end
  end

  // line k carries bit p of k in phase p, so a pin tied to line k reads back k;
  // a grounded pin reads 0000, line 1 (port 0 second led) reads 0001
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      probe_led    <= '0;
      probe_active <= 1'b0;
    end else if (state_next == scl_pkg::ST_DRIVE || state_next == scl_pkg::ST_SAMPLE) begin
      probe_active <= 1'b1;
      for (int k = 1; k <= scl_pkg::PROBE_LINES; k++) begin
        probe_led[k-1] <= ((4'(k) >> probe_phase) & 4'h1) != 4'h0;
      end
    end else begin
      probe_active <= 1'b0;
      probe_led    <= '0;
    end
  end

  // sampled pin levels build the codes one bit per phase
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < scl_pkg::STRAP_PINS; i++) begin
        code_reg[i] <= scl_pkg::CODE_VSS;
      end
    end else if (state_reg == scl_pkg::ST_SAMPLE) begin
      for (int i = 0; i < scl_pkg::STRAP_PINS; i++) begin
        code_reg[i][phase_reg] <= strap_sync[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clk_sel_reg <= 2'h0;
    end else if (state_reg == scl_pkg::ST_LOAD) begin
      clk_sel_reg <= clk_sel_sync;
    end
  end

  // address straps are latched once and never written by software
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      upper_addr_reg <= 3'h0;
      order_reg      <= 1'b0;
    end else if (state_reg == scl_pkg::ST_LOAD) begin
      upper_addr_reg <= upper_port_address;
      order_reg      <= port_number_order;
    end
  end

  // full port addresses are formed once at load and then only held;
  // order 1 hands the low address bits out in reverse
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int p = 0; p < 4; p++) begin
        port_addr_reg[p] <= 5'h00;
      end
    end else if (state_reg == scl_pkg::ST_LOAD) begin
      for (int p = 0; p < 4; p++) begin
        port_addr_reg[p] <= {upper_port_address, scl_pkg::scl_lower_addr(port_number_order, 2'(p))};
      end
    end
  end

  // ready trails the load by one cycle, so a read stalled across the load
  // still captures the freshly loaded fields before it completes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= loaded;
    end
  end

  // bus access
  assign loaded     = (state_reg == scl_pkg::ST_DONE);
  assign access     = psel && penable;
  assign pready     = ready_reg;
  assign complete   = access && pready;
  assign wr_strobe  = complete && pwrite;

  // one decode serves write and error logic; the read mux decodes paddr by its own case
  assign sel_status = (paddr == scl_pkg::OFS_STATUS);
  assign sel_addr   = (paddr == scl_pkg::OFS_ADDR);
  assign sel_advert = (paddr == scl_pkg::OFS_ADVERT);
  assign sel_ctrl   = (paddr == scl_pkg::OFS_CTRL);
  assign mapped     = sel_status || sel_addr || sel_advert || sel_ctrl;
  assign writable   = sel_advert || sel_ctrl;
  // writes land only on the completing edge
  assign adv_we     = wr_strobe && sel_advert;
  assign ctrl_we    = wr_strobe && sel_ctrl;
  assign pslverr    = complete && (!mapped || (pwrite && !writable));
  assign codes_word = {code_reg[3], code_reg[2], code_reg[1], code_reg[0]};

  assign advert_word = scl_pkg::scl_merge({19'h0, advert_reg}, pwdata, pstrb);
  assign ctrl_word   = scl_pkg::scl_merge({21'h0, ctrl_reg}, pwdata, pstrb);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      advert_reg <= scl_pkg::ADVERT_RESET;
    end else if (state_reg == scl_pkg::ST_LOAD) begin
      advert_reg <= advert_dflt;
    end else if (adv_we) begin
      advert_reg <= advert_word[12:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= scl_pkg::CTRL_RESET;
    end else if (state_reg == scl_pkg::ST_LOAD) begin
      ctrl_reg <= ctrl_dflt;
    end else if (ctrl_we) begin
      ctrl_reg <= ctrl_word[10:0];
    end
  end

  always_comb begin
    read_mux = 32'h0000_0000;
    // status: strap codes on top, clock select and load flag at the bottom
    unique case (paddr)
      scl_pkg::OFS_STATUS: read_mux = {codes_word, 13'h0000, clk_sel_reg, loaded};
      scl_pkg::OFS_ADDR:   read_mux = {28'h000_0000, order_reg, upper_addr_reg};
      scl_pkg::OFS_ADVERT: read_mux = {19'h0_0000, advert_reg};
      scl_pkg::OFS_CTRL:   read_mux = {21'h00_0000, ctrl_reg};
      default:             read_mux = 32'h0000_0000;
    endcase
  end

  // read data is captured until the access completes so it is stable when taken
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !complete) begin
      prdata_reg <= read_mux;
    end
  end

  assign prdata         = prdata_reg;
  assign cfg_loaded     = ready_reg;
  assign ref_clk_select = clk_sel_reg;
  assign advert_cfg     = advert_reg;
  assign ctrl_cfg       = ctrl_reg;
  assign port0_address  = port_addr_reg[0];
  assign port1_address  = port_addr_reg[1];
  assign port2_address  = port_addr_reg[2];
  assign port3_address  = port_addr_reg[3];

endmodule
`default_nettype wire

// >>> testbench/scl_board.sv
// board model: each strap pin tied to ground or to one probe line
// assumes the loader drives probe_led only while probing
`timescale 1ns/1ps
`default_nettype none
module scl_board (
  input  wire logic [14:0] probe_led, // probe lines
  input  wire logic [15:0] tie_line,  // per pin: 0 ground, k line k
  output logic      [3:0]  strap_pin  // strap levels
);
  // a pin tied to line k follows it; ground pulls low
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      strap_pin[i] = (tie_line[i*4 +: 4] == 4'h0) ? 1'b0 : probe_led[tie_line[i*4 +: 4] - 4'h1];
    end
  end
endmodule
`default_nettype wire

// >>> testbench/scl_loader_properties.sv
// checker: load timing, port numbering and register access at the loader ports
// assumes binding to scl_loader
`timescale 1ns/1ps
`default_nettype none
module scl_loader_chk (
  input wire logic        core_clk,      // clock
  input wire logic        reset,         // reset
  input wire logic [14:0] probe_led,     // probe
  input wire logic        probe_active,  // probing
  input wire logic        cfg_loaded,    // loaded
  input wire logic [4:0]  port0_address, // port 0
  input wire logic [4:0]  port1_address, // port 1
  input wire logic [4:0]  port3_address, // port 3
  input wire logic [12:0] advert_cfg,    // advert
  input wire logic [10:0] ctrl_cfg,      // control
  input wire logic [11:0] paddr,         // apb
  input wire logic        psel,          // apb
  input wire logic        penable,       // apb
  input wire logic        pwrite,        // apb
  input wire logic [31:0] pwdata,        // apb
  input wire logic [3:0]  pstrb,         // apb
  input wire logic [31:0] prdata,        // apb
  input wire logic        pready,        // apb
  input wire logic        pslverr        // apb
);
  logic [7:0]  since_rst_reg;
  logic [12:0] wr_low;
  logic        acc;
  assign acc = psel && penable && pready;
  assign wr_low = pwdata[12:0];
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      since_rst_reg <= 8'h00;
    end else if (since_rst_reg != 8'hff) begin
      since_rst_reg <= since_rst_reg + 8'h01;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_settle_before_load: assert property (cfg_loaded |-> since_rst_reg >= 8'h14)
    else $error("load came before the settle time");
  chk_load_holds: assert property (cfg_loaded |=> cfg_loaded)
    else $error("load flag dropped");
  chk_probe_ends: assert property ($rose(cfg_loaded) |-> pready && !probe_active && probe_led == 15'h0000)
    else $error("probe still active after load");
  chk_port_order: assert property (cfg_loaded |-> port1_address == (port0_address ^ 5'h01)
    && port3_address == (port0_address ^ 5'h03) && port0_address[0] == port0_address[1])
    else $error("port numbering wrong");
  chk_addr_ro: assert property (acc && pwrite && paddr == 12'h004 |-> pslverr ##1 $stable(port0_address))
    else $error("address write not refused");
  chk_unmapped_err: assert property (acc && paddr > 12'h00c |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  chk_advert_write: assert property (acc && pwrite && paddr == 12'h008 && pstrb == 4'hf
    |=> advert_cfg == $past(wr_low))
    else $error("advert write lost");
  chk_pair_bits: assert property ($rose(cfg_loaded) |-> ctrl_cfg[6] == ctrl_cfg[7] && ctrl_cfg[0] == ctrl_cfg[1])
    else $error("paired control bits differ");
endmodule
bind scl_loader scl_loader_chk chk_i (.core_clk(core_clk), .reset(reset), .probe_led(probe_led),
  .probe_active(probe_active), .cfg_loaded(cfg_loaded), .port0_address(port0_address),
  .port1_address(port1_address), .port3_address(port3_address), .advert_cfg(advert_cfg),
  .ctrl_cfg(ctrl_cfg), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// >>> testbench/testbench.sv
// testbench: random straps with swept mode and autoneg straps per reset, loaded fields and apb register access
// assumes scl_loader and the board model scl_board
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [1:0]  clk_sel_pin = 2'h0;
  logic [15:0] tie_line = 16'h0000;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic [3:0]  strap_pin;
  logic [14:0] probe_led;
  logic        probe_active, cfg_loaded, pready, pslverr;
  logic [1:0]  ref_clk_select;
  logic [4:0]  port0_address, port1_address, port2_address, port3_address;
  logic [12:0] advert_cfg;
  logic [10:0] ctrl_cfg;
  logic [31:0] prdata;
  int          mismatches = 0;
  int          samples_checked = 0;
  logic [32:0] exp_q[$];
  always #50 core_clk = ~core_clk;
  scl_board board (.probe_led(probe_led), .tie_line(tie_line), .strap_pin(strap_pin));
  scl_loader uut (.core_clk(core_clk), .reset(reset), .strap_pin(strap_pin), .clk_sel_pin(clk_sel_pin),
    .probe_led(probe_led), .probe_active(probe_active), .cfg_loaded(cfg_loaded), .ref_clk_select(ref_clk_select),
    .port0_address(port0_address), .port1_address(port1_address), .port2_address(port2_address),
    .port3_address(port3_address), .advert_cfg(advert_cfg), .ctrl_cfg(ctrl_cfg), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // {error, read data} is noted per transfer and compared at completion
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                     input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge core_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      check({pslverr, pwrite ? 32'h0000_0000 : prdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end
  initial begin
    logic [3:0]  c0, c1, c2, c3;
    logic [1:0]  cs;
    logic [2:0]  pd;
    logic [12:0] adv;
    logic [10:0] ctl;
    logic [19:0] pa;
    logic [31:0] r;
    void'($urandom(82));
    for (int i = 0; i < 16; i++) begin
      c0 = 4'($urandom);
      c1 = 4'($urandom);
      c2 = {i[3], 3'($urandom)};
      c3 = {1'b0, i[2:0]};
      cs = 2'($urandom);
      case (c3[2:0])
        3'h0, 3'h1: pd = 3'h1;
        3'h2, 3'h3, 3'h4: pd = 3'h2;
        3'h5: pd = 3'h4;
        default: pd = 3'h3;
      endcase
      adv = {{2{c1[3]}}, {4{c1[2]}}, c1[0] ? 2'h3 : 2'h1, c1[0], {4{c1[1]}}};
      ctl = {c2[0] ? pd : 3'h0, {2{c2[3]}}, c3[2:0], c2[2], {2{~c2[1]}}};
      clk_sel_pin <= cs;
      tie_line <= {c3, c2, c1, c0};
      reset <= 1'b1;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      if (i[0]) apb(12'h00c, 1'b0, 32'h0, 4'h0, 33'(ctl));
      for (int n = 0; n < 100 && cfg_loaded !== 1'b1; n++) @(posedge core_clk);
      pa = {port3_address, port2_address, port1_address, port0_address};
      check(33'(cfg_loaded), 33'h1);
      for (int k = 0; k < 4; k++) check(33'(pa[k*5 +: 5]), 33'({c0[2:0], c0[3] ? 2'(3 - k) : 2'(k)}));
      check(33'(ref_clk_select), 33'(cs));
      check(33'(advert_cfg), 33'(adv));
      check(33'(ctrl_cfg), 33'(ctl));
      apb(12'h000, 1'b0, 32'h0, 4'h0, {1'b0, c3, c2, c1, c0, 13'h0000, cs, 1'b1});
      apb(12'h004, 1'b0, 32'h0, 4'h0, 33'(c0));
      apb(12'h00c, 1'b0, 32'h0, 4'h0, 33'(ctl));
      r = $urandom;
      apb(12'h008, 1'b1, r, 4'hf, 33'h0);
      apb(12'h008, 1'b0, 32'h0, 4'h0, 33'(r[12:0]));
      apb(12'h008, 1'b1, ~r, 4'h1, 33'h0);
      apb(12'h008, 1'b0, 32'h0, 4'h0, 33'({r[12:8], ~r[7:0]}));
      apb(12'h00c, 1'b1, r, 4'h3, 33'h0);
      apb(12'h00c, 1'b0, 32'h0, 4'h0, 33'(r[10:0]));
      apb(12'h004, 1'b1, r, 4'hf, 33'h1_0000_0000);
      apb(12'h004, 1'b0, 32'h0, 4'h0, 33'(c0));
      apb(12'h010 + 12'(4 * i), 1'b0, 32'h0, 4'h0, 33'h1_0000_0000);
      $display("test %0d done", i);
    end
    repeat (2) @(posedge core_clk);
    end_sim();
  end
endmodule
`default_nettype wire
